// File: core/sbrmf_defs.vh
// constants for the byte register management frame slave
`ifndef SBRMF_DEFS_VH
`define SBRMF_DEFS_VH
`define SBRMF_PREAMBLE_LEN 6'h20
`define SBRMF_OP_BYTE 2'h0
`define SBRMF_OP_PHY_RD 2'h2
`define SBRMF_OP_PHY_WR 2'h1
`define SBRMF_PHY_RD_BIT 4
`define SBRMF_REG_MAX 8'h8D
`define SBRMF_REG_COUNT 142
`define SBRMF_REG_RESET 8'h00
`define SBRMF_PHY_REG_RESET 16'h0000
`define SBRMF_PHY_ADDR 5'h01
`define SBRMF_MDC_MAX_MHZ 5
`endif

// File: core/sbrmf_mdc_edge.v
// link clock synchroniser and rising and falling edge finder
`timescale 1ns/1ns
`default_nettype none
module sbrmf_mdc_edge (
  input wire core_clk,
  input wire rst,
  input wire mdc,
  input wire mdio_in,
  output reg mdc_rise,
  output reg mdc_fall,
  output reg mdio_s
);
  reg mdc_m_r;
  reg mdc_s_r;
  reg mdc_d_r;
  reg mdio_m_r;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mdc_m_r <= 1'b0;
      mdc_s_r <= 1'b0;
      mdc_d_r <= 1'b0;
      mdio_m_r <= 1'b1;
      mdio_s <= 1'b1;
      mdc_rise <= 1'b0;
      mdc_fall <= 1'b0;
    end else begin
      mdc_m_r <= mdc;
      mdc_s_r <= mdc_m_r;
      mdc_d_r <= mdc_s_r;
      mdio_m_r <= mdio_in;
      mdio_s <= mdio_m_r;
      mdc_rise <= mdc_s_r & ~mdc_d_r;
      mdc_fall <= ~mdc_s_r & mdc_d_r;
    end
  end
endmodule // sbrmf_mdc_edge
`default_nettype wire

// File: core/sbrmf_top.v
// byte register management frame slave over mdc/mdio
// Function
// - preamble 32 ones, start 01, standard framing
// - opcode 00, phy bit4 one: read
// - opcode 00, phy bit4 zero: write
// - phy address bit3 ignored
// - index is phy[2:0] above reg[4:0]
// - indices 0..141, phy regs 0-5,29,31
// - eight bit registers in low data byte
// - read drives zero upper byte first
// - write ignores upper data byte
// - read turnaround: release, then drive zero
// - opcode 10 read, 01 write, 16 bit
`timescale 1ns/1ns
`default_nettype none
`include "sbrmf_defs.vh"
module sbrmf_top (
  input wire core_clk,
  input wire rst,
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe,
  output reg [7:0] wr_index,
  output reg [7:0] wr_data,
  output reg wr_strobe
);
  localparam [6:0] ST_PRE = 7'h01;
  localparam [6:0] ST_START = 7'h02;
  localparam [6:0] ST_HDR = 7'h04;
  localparam [6:0] ST_TA = 7'h08;
  localparam [6:0] ST_DATA = 7'h10;
  localparam [6:0] ST_SKIP = 7'h20;
  localparam [6:0] ST_IDLE = 7'h40;

  wire mdc_rise;
  wire mdc_fall;
  wire mdio_s;
  reg [6:0] state_r;
  reg [5:0] cnt_r;
  reg [11:0] hdr_r;
  reg [15:0] shift_r;
  reg rd_r;
  reg byte_r;
  reg [7:0] regs [0:`SBRMF_REG_COUNT-1];
  reg [15:0] phy_regs [0:7];
  integer i;

  sbrmf_mdc_edge u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdc_rise(mdc_rise),
    .mdc_fall(mdc_fall),
    .mdio_s(mdio_s)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function [7:0] byte_index;
    input [9:0] ad;
    begin
      byte_index = {ad[7:5], ad[4:0]};
    end
  endfunction

  // maps phy register number to slot; unmatched numbers give 0, so phy_hit must guard
  function [2:0] phy_slot;
    input [4:0] ra;
    begin
      if (ra <= 5'h05)
        phy_slot = ra[2:0];
      else if (ra == 5'h1D)
        phy_slot = 3'h6;
      else if (ra == 5'h1F)
        phy_slot = 3'h7;
      else
        phy_slot = 3'h0;
    end
  endfunction

  function phy_hit;
    input [4:0] ra;
    begin
      phy_hit = (ra <= 5'h05) | (ra == 5'h1D) | (ra == 5'h1F);
    end
  endfunction

  wire [1:0] op_w = hdr_r[11:10];
  wire [4:0] pa_w = hdr_r[9:5];
  wire [4:0] ra_w = hdr_r[4:0];
  wire [7:0] idx_w = byte_index(hdr_r[9:0]);
  wire idx_ok_w = idx_w <= `SBRMF_REG_MAX;
  wire phy_ok_w = (pa_w == `SBRMF_PHY_ADDR) & phy_hit(ra_w);

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_PRE;
      cnt_r <= 6'h00;
      hdr_r <= 12'h000;
      shift_r <= 16'h0000;
      rd_r <= 1'b0;
      byte_r <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      wr_index <= 8'h00;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
      for (i = 0; i < `SBRMF_REG_COUNT; i = i + 1)
        regs[i] <= `SBRMF_REG_RESET;
      for (i = 0; i < 8; i = i + 1)
        phy_regs[i] <= `SBRMF_PHY_REG_RESET;
    end else begin
      wr_strobe <= 1'b0;
      if (mdc_fall && state_r == ST_DATA && rd_r) begin
        mdio_out <= shift_r[15];
        mdio_oe <= 1'b1;
      end
      if (mdc_rise) begin
        case (state_r)
          ST_PRE: begin
            if (!mdio_s)
              cnt_r <= 6'h00;
            else if (cnt_r != `SBRMF_PREAMBLE_LEN)
              cnt_r <= cnt_r + 6'h01;
            if (!mdio_s && cnt_r == `SBRMF_PREAMBLE_LEN)
              state_r <= ST_START;
          end
          ST_START: begin
            cnt_r <= 6'h00;
            state_r <= mdio_s ? ST_HDR : ST_PRE;
          end
          ST_HDR: begin
            hdr_r <= {hdr_r[10:0], mdio_s};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h0B)
              state_r <= ST_TA;
            if (cnt_r == 6'h0B)
              cnt_r <= 6'h00;
          end
          ST_TA: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h00) begin
              byte_r <= op_w == `SBRMF_OP_BYTE;
              rd_r <= (op_w == `SBRMF_OP_BYTE && pa_w[`SBRMF_PHY_RD_BIT]) ||
                      (op_w == `SBRMF_OP_PHY_RD && phy_ok_w);
              if (op_w == `SBRMF_OP_BYTE)
                shift_r <= {8'h00, idx_ok_w ? regs[idx_w] : 8'h00};
              else
                shift_r <= phy_ok_w ? phy_regs[phy_slot(ra_w)] : 16'h0000;
              if (op_w == `SBRMF_OP_PHY_WR || op_w == `SBRMF_OP_BYTE ||
                  op_w == `SBRMF_OP_PHY_RD) begin
                if ((op_w == `SBRMF_OP_BYTE && pa_w[`SBRMF_PHY_RD_BIT]) ||
                    (op_w == `SBRMF_OP_PHY_RD && phy_ok_w)) begin
                  mdio_out <= 1'b0;
                  mdio_oe <= 1'b1;
                end
              end else
                state_r <= ST_SKIP;
            end else begin
              cnt_r <= 6'h00;
              state_r <= ST_DATA;
            end
          end
          ST_DATA: begin
            cnt_r <= cnt_r + 6'h01;
            if (rd_r)
              shift_r <= {shift_r[14:0], 1'b0};
            else
              shift_r <= {shift_r[14:0], mdio_s};
            if (cnt_r == 6'h0F) begin
              state_r <= ST_IDLE;
              if (!rd_r && byte_r && idx_ok_w) begin
                regs[idx_w] <= {shift_r[6:0], mdio_s};
                wr_index <= idx_w;
                wr_data <= {shift_r[6:0], mdio_s};
                wr_strobe <= 1'b1;
              end
              if (!rd_r && !byte_r && phy_ok_w)
                phy_regs[phy_slot(ra_w)] <= {shift_r[14:0], mdio_s};
            end
          end
          // skip ends on data bit 0 so the idle bit is consumed by the idle state
          ST_SKIP: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h11)
              state_r <= ST_IDLE;
          end
          ST_IDLE: begin
            mdio_oe <= 1'b0;
            cnt_r <= 6'h00;
            state_r <= ST_PRE;
          end
          default: state_r <= ST_PRE;
        endcase
      end
    end
  end
endmodule // sbrmf_top
`default_nettype wire

// File: verif/sbrmf_chk.sv
// port assertions for the byte register management slave
`timescale 1ns/1ns
`default_nettype none
module sbrmf_chk (
  input wire core_clk,
  input wire rst,
  input wire mdc,
  input wire mdio_in,
  input wire mdio_out,
  input wire mdio_oe,
  input wire [7:0] wr_index,
  input wire [7:0] wr_data,
  input wire wr_strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe) else $error("strobe long");
  strobe_range_a: assert property (wr_strobe |-> wr_index <= 8'h8D) else $error("bad index");
  write_hold_a: assert property (($changed(wr_index) || $changed(wr_data)) |-> wr_strobe)
    else $error("write moved");
  write_quiet_a: assert property (wr_strobe |-> !mdio_oe) else $error("drive on write");
  ta_zero_a: assert property ($rose(mdio_oe) |-> (!mdio_out)[*8]) else $error("turnaround");
  read_span_a: assert property ($rose(mdio_oe) |-> ##250 mdio_oe ##[10:40] !mdio_oe)
    else $error("read span");
  out_change_a: assert property ((mdio_oe && $past(mdio_oe) && $changed(mdio_out)) |-> !mdc)
    else $error("late change");
  idle_drop_a: assert property ($fell(mdio_oe) |-> mdc) else $error("release");
endmodule // sbrmf_chk
bind sbrmf_top sbrmf_chk u_chk (.core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .wr_index(wr_index), .wr_data(wr_data), .wr_strobe(wr_strobe));
`default_nettype wire

// File: verif/sbrmf_ctrl_model.sv
// management controller model driving mdc and mdio
`timescale 1ns/1ns
`default_nettype none
module sbrmf_ctrl_model (
  input wire core_clk,
  input wire mdio,
  output var logic mdc,
  output var logic ctrl_oe,
  output var logic ctrl_out
);
  initial begin
    mdc = 1'b0;
    ctrl_oe = 1'b0;
    ctrl_out = 1'b0;
  end
  task bit_t(input o, input v, output s);
    begin
      ctrl_oe <= o;
      ctrl_out <= v;
      repeat (8) @(posedge core_clk);
      mdc <= 1'b1;
      s = mdio;
      repeat (8) @(posedge core_clk);
      mdc <= 1'b0;
    end
  endtask
  task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd, output [15:0] rd, output ta0);
    reg [45:0] hd;
    reg rdf;
    reg s;
    integer i;
    begin
      hd = {32'hffff_ffff, 2'b01, op, pa, ra};
      rdf = (op != 2'b01) && (op != 2'b00 || pa[4]);
      for (i = 45; i >= 0; i = i - 1)
        bit_t(1'b1, hd[i], s);
      bit_t(!rdf, 1'b1, s);
      bit_t(!rdf, 1'b0, ta0);
      for (i = 15; i >= 0; i = i - 1) begin
        bit_t(!rdf, wd[i], s);
        rd[i] = s;
      end
      bit_t(1'b0, 1'b0, s);
    end
  endtask
endmodule // sbrmf_ctrl_model
`default_nettype wire

// File: verif/sbrmf_testbench.sv
// random and corner frames through the management slave
`timescale 1ns/1ns
`default_nettype none
module testbench;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] seed = 32'he35e;
  wire mdc, c_oe, c_out, mdio_out, mdio_oe, wr_strobe;
  wire [7:0] wr_index, wr_data;
  // pull-up: a released line reads high, never a stale value
  wire mdio = mdio_oe ? mdio_out : (c_oe ? c_out : 1'b1);
  integer n_errors = 0;
  integer checks_done = 0;
  integer n_strobe = 0;
  integer k, nst;
  reg [31:0] r, r2;
  reg [15:0] rd;
  reg ta;
  reg [7:0] idx;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (wr_strobe === 1'b1)
      n_strobe <= n_strobe + 1;
  sbrmf_top DUT (.core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .wr_index(wr_index), .wr_data(wr_data), .wr_strobe(wr_strobe));
  sbrmf_ctrl_model model (.core_clk(core_clk), .mdio(mdio), .mdc(mdc), .ctrl_oe(c_oe), .ctrl_out(c_out));
  function [15:0] exp_rd(input [7:0] ix, input [7:0] d);
    exp_rd = (ix <= 8'h8D) ? {8'h00, d} : 16'h0000;
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // upper data byte and phy bit 3 are random junk
  task wr_rd(input [7:0] ix, input [31:0] v);
    begin
      nst = n_strobe;
      model.frame(2'b00, {1'b0, v[16], ix[7:5]}, ix[4:0], v[15:0], rd, ta);
      check({15'h0, n_strobe != nst}, {15'h0, ix <= 8'h8D});
      if (ix <= 8'h8D)
        check({wr_index, wr_data}, {ix, v[7:0]});
      model.frame(2'b00, {1'b1, ~v[16], ix[7:5]}, ix[4:0], 16'h0, rd, ta);
      check(rd, exp_rd(ix, v[7:0]));
      check({15'h0, ta}, 16'h0000);
      $display("pair at %h done", ix);
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (k = 0; k < 10; k = k + 1) begin
      r = {$random(seed)} % 142;
      r2 = $random(seed);
      idx = k == 0 ? 8'h00 : k == 1 ? 8'h8D : k == 2 ? 8'h8E : k == 3 ? 8'hFF : r[7:0];
      wr_rd(idx, r2);
    end
    // mid-run reset must clear wr_index, wr_data and the last written byte register
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check({wr_index, wr_data}, 16'h0000);
    model.frame(2'b00, {2'b10, idx[7:5]}, idx[4:0], 16'h0, rd, ta);
    check(rd, 16'h0000);
    $display("reset test done");
    r2 = $random(seed);
    model.frame(2'b01, 5'h01, 5'd29, r2[15:0], rd, ta);
    model.frame(2'b10, 5'h01, 5'd29, 16'h0, rd, ta);
    check(rd, r2[15:0]);
    model.frame(2'b11, 5'h01, 5'd29, 16'h0, rd, ta);
    check(rd, 16'hffff);
    $display("phy frames done");
    close_out;
  end
  initial begin
    #600000;
    n_errors = n_errors + 1;
    close_out;
  end
endmodule // testbench
`default_nettype wire
